// [core/qpe_defs.vh]
// Constants for the command and completion ring engine
`ifndef QPE_DEFS_VH
`define QPE_DEFS_VH
`define QPE_CMD_BYTES    64
`define QPE_CMD_W        512
`define QPE_SLOT_SHIFT   6
`define QPE_CPL_W        128
`define QPE_PTR_W        16
`define QPE_ID_W         16
`define QPE_ADMIN_ID     16'h0000
`define QPE_FIFO_DEPTH   16
`define QPE_FIFO_AW      4
`define QPE_NUM_RINGS    4
`define QPE_RIDX_W       2
`define QPE_CMD_CID_LSB  16
`define QPE_CMD_PP1_LSB  192
`define QPE_CMD_PP2_LSB  256
`define QPE_PP_W         64
`define QPE_CPL_RSVD     32'h00000000
`define QPE_PHASE_RESET  1'b1
`define QPE_F_IDLE       2'h0
`define QPE_F_REQ        2'h1
`define QPE_F_WAIT       2'h2
`endif

// [core/qpe_engine.v]
// Command ring fetch and completion ring post engine with command FIFO
`timescale 1ns/1ps
`include "qpe_defs.vh"

module qpe_fifo #(
    parameter W     = 8,
    parameter DEPTH = `QPE_FIFO_DEPTH,
    parameter AW    = `QPE_FIFO_AW
) (
    input  wire         clk_sys,
    input  wire         sys_rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:DEPTH-1];  // Storage
    reg [AW-1:0] wr_reg;          // Write pointer
    reg [AW-1:0] rd_reg;          // Read pointer
    reg [AW:0]   cnt_reg;         // Occupancy
    reg          in_ready_reg;    // Room left
    reg          out_valid_reg;   // Data held
    wire         push;
    wire         pop;
    wire [AW:0]  cnt_next;

    assign push      = in_valid & in_ready_reg;
    assign pop       = out_valid_reg & out_ready;
    assign cnt_next  = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign in_ready  = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data  = mem[rd_reg];

    // Storage write, no reset needed
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Pointers and honest full/empty flags
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_reg        <= {AW{1'b0}};
            rd_reg        <= {AW{1'b0}};
            cnt_reg       <= {(AW+1){1'b0}};
            in_ready_reg  <= 1'b1;
            out_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH - 1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            cnt_reg       <= cnt_next;
            in_ready_reg  <= (cnt_next != DEPTH);
            out_valid_reg <= (cnt_next != {(AW+1){1'b0}});
        end
    end
endmodule

module qpe_engine #(
    parameter NUM_RINGS = `QPE_NUM_RINGS,
    parameter RIDX_W    = `QPE_RIDX_W,
    parameter FIFO_DEPTH = `QPE_FIFO_DEPTH,
    parameter FIFO_AW   = `QPE_FIFO_AW
) (
    input  wire                   clk_sys,
    input  wire                   sys_rst,
    input  wire                   cfg_wr,
    input  wire [`QPE_ID_W-1:0]   cfg_ring,
    input  wire [`QPE_PTR_W-1:0]  cfg_cmd_size,
    input  wire [`QPE_PTR_W-1:0]  cfg_cpl_size,
    input  wire [`QPE_ID_W-1:0]   cfg_map,
    input  wire                   cfg_enable,
    input  wire                   db_wr,
    input  wire                   db_is_tail,
    input  wire [`QPE_ID_W-1:0]   db_ring,
    input  wire [`QPE_PTR_W-1:0]  db_value,
    output wire                   fetch_req_valid,
    input  wire                   fetch_req_ready,
    output wire [`QPE_ID_W-1:0]   fetch_ring,
    output wire [`QPE_PTR_W-1:0]  fetch_slot,
    output wire [`QPE_PTR_W+5:0]  fetch_offset,
    input  wire                   fetch_rsp_valid,
    input  wire [`QPE_CMD_W-1:0]  fetch_rsp_data,
    output wire                   cmd_valid,
    input  wire                   cmd_ready,
    output wire [`QPE_CMD_W-1:0]  cmd_data,
    output wire [`QPE_ID_W-1:0]   cmd_ring,
    output wire [`QPE_ID_W-1:0]   cmd_id,
    output wire [`QPE_PP_W-1:0]   cmd_pp1,
    output wire [`QPE_PP_W-1:0]   cmd_pp2,
    input  wire                   cpl_valid,
    output wire                   cpl_ack,
    input  wire [`QPE_ID_W-1:0]   cpl_ring,
    input  wire [`QPE_ID_W-1:0]   cpl_cmd_id,
    input  wire [14:0]            cpl_status,
    input  wire [31:0]            cpl_specific,
    output wire                   post_valid,
    input  wire                   post_ready,
    output wire [`QPE_ID_W-1:0]   post_ring,
    output wire [`QPE_PTR_W-1:0]  post_slot,
    output wire [`QPE_CPL_W-1:0]  post_entry
);
    localparam FW = `QPE_CMD_W + `QPE_ID_W;  // FIFO word: command plus ring
    localparam PW = `QPE_PTR_W;

    // Fetch side registers
    reg [1:0]          fst_reg;          // Fetch state
    reg [RIDX_W-1:0]   scan_reg;         // Round robin scan index
    reg                fetch_req_valid_reg;
    reg [`QPE_ID_W-1:0] fetch_ring_reg;
    reg [PW-1:0]       fetch_slot_reg;
    reg [PW+5:0]       fetch_offset_reg;
    reg                push_reg;         // One-cycle FIFO write
    reg [FW-1:0]       push_data_reg;
    // Completion side registers
    reg                cpl_ack_reg;
    reg                post_valid_reg;
    reg [`QPE_ID_W-1:0] post_ring_reg;
    reg [PW-1:0]       post_slot_reg;
    reg [`QPE_CPL_W-1:0] post_entry_reg;

    // Flattened per-ring state for indexed reads
    wire [NUM_RINGS*PW-1:0]     tail_f;
    wire [NUM_RINGS*PW-1:0]     fptr_f;
    wire [NUM_RINGS*RIDX_W-1:0] map_f;
    wire [NUM_RINGS-1:0]        en_f;
    wire [NUM_RINGS*PW-1:0]     ctail_f;
    wire [NUM_RINGS*PW-1:0]     chead_f;
    wire [NUM_RINGS*PW-1:0]     csize_f;
    wire [NUM_RINGS-1:0]        phase_f;

    wire              fifo_in_ready;
    wire [FW-1:0]     fifo_out;
    wire [RIDX_W-1:0] cfg_idx  = cfg_ring[RIDX_W-1:0];
    wire [RIDX_W-1:0] db_idx   = db_ring[RIDX_W-1:0];
    wire [RIDX_W-1:0] cpl_idx  = cpl_ring[RIDX_W-1:0];
    wire [RIDX_W-1:0] fidx     = fetch_ring_reg[RIDX_W-1:0];

    // Admin ring pairs only with completion zero; others never use it
    wire cfg_ok = cfg_wr && (cfg_ring < NUM_RINGS) && (cfg_map < NUM_RINGS) &&
                  ((cfg_ring == `QPE_ADMIN_ID) == (cfg_map == `QPE_ADMIN_ID));
    wire db_ok  = db_wr && (db_ring < NUM_RINGS);
    wire fetch_done = (fst_reg == `QPE_F_WAIT) && fetch_rsp_valid;

    // Completion target lookup
    wire              cpl_in_range = (cpl_ring < NUM_RINGS);
    wire [RIDX_W-1:0] cq_idx   = map_f[cpl_idx*RIDX_W +: RIDX_W];
    wire [PW-1:0]     cq_tail  = ctail_f[cq_idx*PW +: PW];
    wire [PW-1:0]     cq_size  = csize_f[cq_idx*PW +: PW];
    wire [PW-1:0]     cq_head  = chead_f[cq_idx*PW +: PW];
    wire              cq_full  = (qpe_wrap(cq_tail, cq_size) == cq_head);
    wire              cpl_free = cpl_valid && !post_valid_reg && !cpl_ack_reg;
    wire              cpl_good = cpl_in_range && en_f[cpl_idx];
    wire              cpl_take = cpl_free && cpl_good && !cq_full;
    wire              cpl_drop = cpl_free && !cpl_good;

    // Scan candidate for fetch
    wire [PW-1:0] scan_tail = tail_f[scan_reg*PW +: PW];
    wire [PW-1:0] scan_fptr = fptr_f[scan_reg*PW +: PW];
    wire          scan_hit  = en_f[scan_reg] && (scan_fptr != scan_tail);

    // Next pointer with wrap at 0's based ring size
    function [PW-1:0] qpe_wrap;
        input [PW-1:0] p;
        input [PW-1:0] s;
        begin
            qpe_wrap = (p == s) ? {PW{1'b0}} : p + 1'b1;
        end
    endfunction

    // Per-ring pointer state for 4 rings (2-bit index); 16-bit pointers allow 64K entries per ring
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RINGS; gi = gi + 1) begin : g_ring
            reg [PW-1:0]     tail_reg;   // Host tail, command ring
            reg [PW-1:0]     fptr_reg;   // Fetch pointer
            reg [PW-1:0]     size_reg;   // Command ring size, 0's based
            reg [RIDX_W-1:0] map_reg;    // Completion ring target
            reg              en_reg;     // Ring pair in use
            reg [PW-1:0]     ctail_reg;  // Completion post pointer
            reg [PW-1:0]     chead_reg;  // Host completion head
            reg [PW-1:0]     csize_reg;  // Completion ring size
            reg              phase_reg;  // Phase written this pass
            wire sel_cfg  = cfg_ok && (cfg_idx == gi);
            wire sel_db   = db_ok && (db_idx == gi);
            wire sel_post = cpl_take && (cq_idx == gi);

            always @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    tail_reg  <= {PW{1'b0}};
                    fptr_reg  <= {PW{1'b0}};
                    size_reg  <= {PW{1'b0}};
                    map_reg   <= {RIDX_W{1'b0}};
                    en_reg    <= 1'b0;
                    ctail_reg <= {PW{1'b0}};
                    chead_reg <= {PW{1'b0}};
                    csize_reg <= {PW{1'b0}};
                    phase_reg <= `QPE_PHASE_RESET;
                end else if (sel_cfg) begin
                    // Setup restarts both rings
                    size_reg  <= cfg_cmd_size;
                    csize_reg <= cfg_cpl_size;
                    map_reg   <= cfg_map[RIDX_W-1:0];
                    en_reg    <= cfg_enable;
                    tail_reg  <= {PW{1'b0}};
                    fptr_reg  <= {PW{1'b0}};
                    ctail_reg <= {PW{1'b0}};
                    chead_reg <= {PW{1'b0}};
                    phase_reg <= `QPE_PHASE_RESET;
                end else begin
                    if (sel_db && db_is_tail) begin
                        tail_reg <= db_value;
                    end
                    if (sel_db && !db_is_tail) begin
                        chead_reg <= db_value;
                    end
                    if (fetch_done && (fidx == gi)) begin
                        fptr_reg <= qpe_wrap(fptr_reg, size_reg);
                    end
                    if (sel_post) begin
                        ctail_reg <= qpe_wrap(ctail_reg, csize_reg);
                        if (ctail_reg == csize_reg) begin
                            phase_reg <= ~phase_reg;
                        end
                    end
                end
            end

            assign tail_f[gi*PW +: PW]         = tail_reg;
            assign fptr_f[gi*PW +: PW]         = fptr_reg;
            assign map_f[gi*RIDX_W +: RIDX_W]  = map_reg;
            assign en_f[gi]                    = en_reg;
            assign ctail_f[gi*PW +: PW]        = ctail_reg;
            assign chead_f[gi*PW +: PW]        = chead_reg;
            assign csize_f[gi*PW +: PW]        = csize_reg;
            assign phase_f[gi]                 = phase_reg;
        end
    endgenerate

    // In-order fetch, one outstanding, only while FIFO has room
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fst_reg             <= `QPE_F_IDLE;
            scan_reg            <= {RIDX_W{1'b0}};
            fetch_req_valid_reg <= 1'b0;
            fetch_ring_reg      <= {`QPE_ID_W{1'b0}};
            fetch_slot_reg      <= {PW{1'b0}};
            fetch_offset_reg    <= {(PW+6){1'b0}};
            push_reg            <= 1'b0;
            push_data_reg       <= {FW{1'b0}};
        end else begin
            push_reg <= 1'b0;
            case (fst_reg)
                `QPE_F_IDLE: begin
                    // A write still in flight has not yet lowered the room flag
                    if (scan_hit && fifo_in_ready && !push_reg) begin
                        // Next slot of this ring, 64-byte stride
                        fetch_req_valid_reg <= 1'b1;
                        fetch_ring_reg      <= {{(`QPE_ID_W-RIDX_W){1'b0}}, scan_reg};
                        fetch_slot_reg      <= scan_fptr;
                        fetch_offset_reg    <= {scan_fptr, 6'h00};
                        fst_reg             <= `QPE_F_REQ;
                    end else begin
                        scan_reg <= scan_reg + 1'b1;
                    end
                end
                `QPE_F_REQ: begin
                    // Hold request until memory path takes it
                    if (fetch_req_ready) begin
                        fetch_req_valid_reg <= 1'b0;
                        fst_reg             <= `QPE_F_WAIT;
                    end
                end
                `QPE_F_WAIT: begin
                    // Whole 64-byte command arrives in one beat
                    if (fetch_rsp_valid) begin
                        push_reg      <= 1'b1;
                        push_data_reg <= {fetch_ring_reg, fetch_rsp_data};
                        scan_reg      <= scan_reg + 1'b1;
                        fst_reg       <= `QPE_F_IDLE;
                    end
                end
                default: begin
                    fst_reg <= `QPE_F_IDLE;
                end
            endcase
        end
    end

    // Command FIFO toward dispatch; stall here stops fetching
    qpe_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (push_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_reg),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready),
        .out_data  (fifo_out)
    );

    // Completion intake and post toward host memory
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cpl_ack_reg    <= 1'b0;
            post_valid_reg <= 1'b0;
            post_ring_reg  <= {`QPE_ID_W{1'b0}};
            post_slot_reg  <= {PW{1'b0}};
            post_entry_reg <= {`QPE_CPL_W{1'b0}};
        end else begin
            cpl_ack_reg <= cpl_take | cpl_drop;
            if (post_valid_reg && post_ready) begin
                post_valid_reg <= 1'b0;
            end
            if (cpl_take) begin
                post_valid_reg <= 1'b1;
                post_ring_reg  <= {{(`QPE_ID_W-RIDX_W){1'b0}}, cq_idx};
                post_slot_reg  <= cq_tail;
                // Ring id plus command id name the completion
                post_entry_reg <= {cpl_status, phase_f[cq_idx], cpl_cmd_id, cpl_ring,
                                   fptr_f[cpl_idx*PW +: PW], `QPE_CPL_RSVD, cpl_specific};
            end
        end
    end

    assign fetch_req_valid = fetch_req_valid_reg;
    assign fetch_ring      = fetch_ring_reg;
    assign fetch_slot      = fetch_slot_reg;
    assign fetch_offset    = fetch_offset_reg;
    assign cmd_data        = fifo_out[`QPE_CMD_W-1:0];
    assign cmd_ring        = fifo_out[FW-1:`QPE_CMD_W];
    assign cmd_id          = fifo_out[`QPE_CMD_CID_LSB +: `QPE_ID_W];
    assign cmd_pp1         = fifo_out[`QPE_CMD_PP1_LSB +: `QPE_PP_W];
    assign cmd_pp2         = fifo_out[`QPE_CMD_PP2_LSB +: `QPE_PP_W];
    assign cpl_ack         = cpl_ack_reg;
    assign post_valid      = post_valid_reg;
    assign post_ring       = post_ring_reg;
    assign post_slot       = post_slot_reg;
    assign post_entry      = post_entry_reg;
endmodule

// [verif/qpe_engine_sva.sv]
// Checker for the ring engine ports
`timescale 1ns/1ps
`include "qpe_defs.vh"
module qpe_engine_chk (
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    input wire logic                  fetch_req_valid,
    input wire logic                  fetch_req_ready,
    input wire logic [`QPE_ID_W-1:0]  fetch_ring,
    input wire logic [`QPE_PTR_W-1:0] fetch_slot,
    input wire logic [`QPE_PTR_W+5:0] fetch_offset,
    input wire logic                  cmd_valid,
    input wire logic                  cmd_ready,
    input wire logic [`QPE_CMD_W-1:0] cmd_data,
    input wire logic [`QPE_ID_W-1:0]  cmd_id,
    input wire logic [`QPE_PP_W-1:0]  cmd_pp1,
    input wire logic [`QPE_PP_W-1:0]  cmd_pp2,
    input wire logic                  cpl_valid,
    input wire logic                  cpl_ack,
    input wire logic [`QPE_ID_W-1:0]  cpl_ring,
    input wire logic [`QPE_ID_W-1:0]  cpl_cmd_id,
    input wire logic                  post_valid,
    input wire logic                  post_ready,
    input wire logic [`QPE_ID_W-1:0]  post_ring,
    input wire logic [`QPE_CPL_W-1:0] post_entry
);
    // One clock domain for all checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Request held with its slot until taken
    property p_fetch_hold;
        fetch_req_valid && !fetch_req_ready |=> fetch_req_valid && $stable(fetch_slot) && $stable(fetch_ring);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch request dropped early");
    // Byte offset is slot times 64
    property p_offset;
        fetch_req_valid |-> fetch_offset == {fetch_slot, 6'h00};
    endproperty
    a_offset: assert property (p_offset) else $error("fetch offset not slot times 64");
    // Page pointers and id come from fixed command fields
    property p_cmd_fields;
        cmd_valid |-> cmd_id == cmd_data[31:16] && cmd_pp1 == cmd_data[255:192] && cmd_pp2 == cmd_data[319:256];
    endproperty
    a_cmd_fields: assert property (p_cmd_fields) else $error("command fields misplaced");
    // Dispatched command stable while stalled
    property p_cmd_hold;
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed while stalled");
    // Acknowledge is a single pulse
    property p_ack_pulse;
        cpl_ack |=> !cpl_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    // New post carries ring and command id of its request
    property p_post_ids;
        $rose(post_valid) |-> post_entry[111:80] == {$past(cpl_cmd_id), $past(cpl_ring)};
    endproperty
    a_post_ids: assert property (p_post_ids) else $error("post ids wrong");
    // Posted entry held until taken
    property p_post_hold;
        post_valid && !post_ready |=> post_valid && $stable(post_entry) && $stable(post_ring);
    endproperty
    a_post_hold: assert property (p_post_hold) else $error("post changed while stalled");
    // Reserved dword is zero
    property p_rsvd;
        post_valid |-> post_entry[63:32] == `QPE_CPL_RSVD;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    // Admin ring completes only into admin completion ring
    property p_admin;
        post_valid && post_entry[95:80] == `QPE_ADMIN_ID |-> post_ring == `QPE_ADMIN_ID;
    endproperty
    a_admin: assert property (p_admin) else $error("admin completion misrouted");
    // Main traffic seen
    c_fetch: cover property (fetch_req_valid && fetch_req_ready);
    c_full: cover property (cmd_valid && !cmd_ready ##1 cmd_valid && !cmd_ready);
    c_post: cover property (post_valid && post_ready);
endmodule
bind qpe_engine qpe_engine_chk qpe_engine_chk_i (.clk_sys, .sys_rst, .fetch_req_valid, .fetch_req_ready,
    .fetch_ring, .fetch_slot, .fetch_offset, .cmd_valid, .cmd_ready, .cmd_data, .cmd_id, .cmd_pp1, .cmd_pp2,
    .cpl_valid, .cpl_ack, .cpl_ring, .cpl_cmd_id, .post_valid, .post_ready, .post_ring, .post_entry);

// [verif/qpe_host_model.sv]
// Host memory model answering fetches and taking posts
`timescale 1ns/1ps
`include "qpe_defs.vh"
module qpe_host_model (
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  slow,
    input  wire logic                  fetch_req_valid,
    output logic                       fetch_req_ready,
    input  wire logic [`QPE_ID_W-1:0]  fetch_ring,
    input  wire logic [`QPE_PTR_W-1:0] fetch_slot,
    output logic                       fetch_rsp_valid,
    output logic [`QPE_CMD_W-1:0]      fetch_rsp_data,
    input  wire logic                  post_valid,
    output logic                       post_ready,
    input  wire logic [`QPE_ID_W-1:0]  post_ring,
    input  wire logic [`QPE_PTR_W-1:0] post_slot,
    input  wire logic [`QPE_CPL_W-1:0] post_entry
);
    logic [1:0]  st;         // Fetch service state
    logic [2:0]  cnt;        // Delay counter
    logic [31:0] rs;         // Latched ring and slot
    integer      nfetch;     // Fetches answered
    integer      npost;      // Posts taken
    logic [`QPE_ID_W+`QPE_PTR_W+`QPE_CPL_W-1:0] last; // Last post ring, slot, entry
    // Fetch service: ready, then one 64-byte beat per command
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st <= 2'h0; cnt <= 3'h0; rs <= 32'h0; nfetch <= 0;
            fetch_req_ready <= 1'b0; fetch_rsp_valid <= 1'b0; fetch_rsp_data <= '0;
        end else case (st)
            2'h0: if (fetch_req_valid) begin
                cnt <= cnt + 3'h1;
                if (cnt >= (slow ? 3'h4 : 3'h0)) begin
                    fetch_req_ready <= 1'b1; rs <= {fetch_ring, fetch_slot}; st <= 2'h1;
                end
            end
            2'h1: begin
                fetch_req_ready <= 1'b0; cnt <= 3'h0; st <= 2'h2;
            end
            2'h2: begin
                cnt <= cnt + 3'h1;
                if (cnt >= (slow ? 3'h4 : 3'h0)) begin
                    // Whole slot in one beat, id and two page pointers
                    fetch_rsp_valid <= 1'b1; nfetch <= nfetch + 1; st <= 2'h3;
                    fetch_rsp_data <= {192'h0, rs, 32'h5a5a5a5a, 32'ha5a5a5a5, rs, 160'h0, rs[23:16], rs[7:0], 16'h0};
                end
            end
            default: begin
                // Released data lines show a changed pattern
                fetch_rsp_valid <= 1'b0; fetch_rsp_data <= ~fetch_rsp_data; cnt <= 3'h0; st <= 2'h0;
            end
        endcase
    end
    // Post sink: ready one cycle after valid
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            post_ready <= 1'b0; npost <= 0; last <= '0;
        end else begin
            post_ready <= post_valid && !post_ready;
            if (post_valid && post_ready) begin
                npost <= npost + 1; last <= {post_ring, post_slot, post_entry};
            end
        end
    end
endmodule

// [verif/test_queue_pair_submission_completion.sv]
// Testbench for the ring engine
`timescale 1ns/1ps
`include "qpe_defs.vh"
module test_queue_pair_submission_completion;
    logic clk_sys = 1'b0, sys_rst = 1'b1, slow = 1'b0;
    logic cfg_wr = 0, cfg_enable = 1, db_wr = 0, db_is_tail = 0, cmd_ready = 0, cpl_valid = 0;
    logic [15:0] cfg_ring = 0, cfg_cmd_size = 0, cfg_cpl_size = 0, cfg_map = 0, db_ring = 0, db_value = 0;
    logic [15:0] cpl_ring = 0, cpl_cmd_id = 0;
    logic [14:0] cpl_status = 15'h0012;
    logic [31:0] cpl_specific = 32'hbeef0001;
    logic fq_v, fq_r, fr_v, cmd_valid, cpl_ack, post_valid, post_ready;
    logic [15:0] f_ring, f_slot, cmd_ring, cmd_id, post_ring, post_slot;
    logic [21:0] f_off;
    logic [511:0] fr_d, cmd_data;
    logic [63:0] pp1, pp2;
    logic [127:0] post_entry;
    integer errors = 0, comparisons = 0, i;
    always #25 clk_sys = ~clk_sys;
    qpe_engine qpe_engine_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_ring(cfg_ring),
        .cfg_cmd_size(cfg_cmd_size), .cfg_cpl_size(cfg_cpl_size), .cfg_map(cfg_map), .cfg_enable(cfg_enable),
        .db_wr(db_wr), .db_is_tail(db_is_tail), .db_ring(db_ring), .db_value(db_value), .fetch_req_valid(fq_v),
        .fetch_req_ready(fq_r), .fetch_ring(f_ring), .fetch_slot(f_slot), .fetch_offset(f_off),
        .fetch_rsp_valid(fr_v), .fetch_rsp_data(fr_d), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_data(cmd_data), .cmd_ring(cmd_ring), .cmd_id(cmd_id), .cmd_pp1(pp1), .cmd_pp2(pp2),
        .cpl_valid(cpl_valid), .cpl_ack(cpl_ack), .cpl_ring(cpl_ring), .cpl_cmd_id(cpl_cmd_id),
        .cpl_status(cpl_status), .cpl_specific(cpl_specific), .post_valid(post_valid), .post_ready(post_ready),
        .post_ring(post_ring), .post_slot(post_slot), .post_entry(post_entry));
    qpe_host_model qpe_host_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .fetch_req_valid(fq_v),
        .fetch_req_ready(fq_r), .fetch_ring(f_ring), .fetch_slot(f_slot), .fetch_rsp_valid(fr_v),
        .fetch_rsp_data(fr_d), .post_valid(post_valid), .post_ready(post_ready), .post_ring(post_ring),
        .post_slot(post_slot), .post_entry(post_entry));
    // Compare and count
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait on a flag at falling edges
    task automatic wait_for(input string what, ref logic flag);
        for (i = 0; i < 400 && flag !== 1'b1; i++) @(negedge clk_sys);
        if (i == 400) begin
            check(what, 0, 1);
            final_report;
        end
    endtask
    // Ring pair setup
    task cfg(input [15:0] ring, input [15:0] csz, input [15:0] qsz, input [15:0] map);
        cfg_ring = ring; cfg_cmd_size = csz; cfg_cpl_size = qsz; cfg_map = map; cfg_wr = 1;
        @(negedge clk_sys) cfg_wr = 0;
        @(negedge clk_sys);
    endtask
    // Tail or head doorbell, one write
    task db(input tail, input [15:0] ring, input [15:0] val);
        db_is_tail = tail; db_ring = ring; db_value = val; db_wr = 1;
        @(negedge clk_sys) db_wr = 0;
        @(negedge clk_sys);
    endtask
    // Take one command and compare its fields
    task get_cmd(input [15:0] ring, input [15:0] slot);
        wait_for("cmd_valid", cmd_valid);
        check("cmd_ring", cmd_ring, ring);
        check("cmd_id", cmd_id, {ring[7:0], slot[7:0]});
        check("cmd_pp", {pp1[31:0], pp2[63:32]}, {ring, slot, ring, slot});
        cmd_ready = 1;
        @(negedge clk_sys) cmd_ready = 0;
        @(negedge clk_sys);
    endtask
    // Completion with its expected post, or none for completion ring ffff
    task cpl(input [15:0] ring, input [15:0] cid, input [15:0] q, input [15:0] s, input ph, input full);
        integer n;
        n = qpe_host_model_i.npost;
        cpl_ring = ring; cpl_cmd_id = cid; cpl_valid = 1;
        if (full) begin
            repeat (20) @(negedge clk_sys) check("refused ack", cpl_ack, 0);
            db(0, q, s);
        end
        wait_for("cpl_ack", cpl_ack);
        cpl_valid = 0;
        repeat (4) @(negedge clk_sys);
        check("posts", qpe_host_model_i.npost - n, q != 16'hffff);
        if (q != 16'hffff) begin
            check("post place", qpe_host_model_i.last[159:128], {q, s});
            check("post ids", qpe_host_model_i.last[112:80], {ph, cid, ring});
            check("post status", {qpe_host_model_i.last[127:113], qpe_host_model_i.last[63:32]}, {15'h0012, 32'h0});
        end
    endtask
    // Fill the buffer, overwrite the tail, drain in order
    task fifo_fill;
        db(1, 1, 20);
        repeat (300) @(negedge clk_sys);
        check("fetches when full", qpe_host_model_i.nfetch, 16);
        db(1, 1, 25);
        db(1, 1, 22);
        db(1, 3, 1);
        for (int k = 0; k < 22; k++) get_cmd(1, k);
        repeat (60) @(negedge clk_sys);
        check("fetches total", qpe_host_model_i.nfetch, 22);
    endtask
    // Slow host, pointer wrap at ring size
    task wrap_slow;
        slow = 1;
        db(1, 2, 1);
        get_cmd(2, 0);
        db(1, 2, 0);
        get_cmd(2, 1);
        slow = 0;
    endtask
    // Admin pair and a shared completion ring
    task completions;
        db(1, 0, 1);
        get_cmd(0, 0);
        cpl(0, 16'h0000, 0, 0, 1, 0);
        cpl(1, 16'h0100, 1, 0, 1, 0);
        cpl(2, 16'h0201, 1, 1, 1, 0);
        cpl(1, 16'h0102, 1, 2, 1, 1);
        cpl(2, 16'h0203, 1, 0, 0, 0);
        cpl(5, 16'h0504, 16'hffff, 0, 0, 0);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_sys);
        sys_rst = 0;
        @(negedge clk_sys);
        cfg(0, 3, 3, 0);
        cfg(1, 31, 2, 1);
        cfg(2, 1, 7, 1);
        cfg_enable = 0;
        cfg(3, 3, 3, 3);
        cfg_enable = 1;
        cfg(3, 3, 3, 0);
        fifo_fill;
        wrap_slow;
        completions;
        final_report;
    end
endmodule
